// [inc/acu_irq_map.svh]
// Register offsets, field positions and reset values of the calling-unit interrupt block
`ifndef ACU_IRQ_MAP_SVH
`define ACU_IRQ_MAP_SVH

// Global registers
`define ACU_EVT_STATUS_OFS 8'h00
`define ACU_EVT_MASK_OFS 8'h04
`define ACU_SEQ_STATE_OFS 8'h08
// Line control registers: base plus four bytes per line
`define ACU_LINE_BASE_OFS 8'h10
`define ACU_LINE_STRIDE 8'h04

// Line control field positions
`define ACU_MASTER_EN_BIT 2
`define ACU_MAINT_BIT 3
`define ACU_LINE_EN_BIT 6
`define ACU_DONE_BIT 7
`define ACU_DIGIT_LSB 8
`define ACU_RESP_LSB 12

// Event status: bit per line for done set, then completion
`define ACU_EVT_CMPL_BIT 4

// Reset values
`define ACU_EVT_MASK_RST 5'h00
`define ACU_VECTOR_RST 7'h40

`endif

// [inc/acu_irq_pkg.sv]
// Types shared by the calling-unit interrupt block
package acu_irq_pkg;

  // Interrupt transaction sequencer
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_REQ,
    SEQ_ACK,
    SEQ_MASTER
  } seq_state_t;

  // Response cause order inside each line's 4-bit group
  typedef enum logic [1:0] {
    CAUSE_NEXT_DIGIT,
    CAUSE_DATA_MODE,
    CAUSE_CALL_TIMEOUT,
    CAUSE_POWER_LOSS
  } cause_t;

endpackage : acu_irq_pkg

// [design/acu_interrupt_request_master.sv]
// Done flags, interrupt demand and bus interrupt sequencer of the calling-unit interface
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "acu_irq_map.svh"

module acu_interrupt_request_master #(
  parameter int LINES = 4,
  parameter logic [6:0] VECTOR = `ACU_VECTOR_RST
) (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rd_data, // Read data, cycle after strobe
  output logic irq, // Level interrupt to software
  input wire logic [LINES-1:0] present_next_digit, // Next digit wanted
  input wire logic [LINES-1:0] data_set_status, // Modem in data mode
  input wire logic [LINES-1:0] abandon_call_retry, // Call timer expired
  input wire logic [LINES-1:0] power_indication, // Calling unit lost power
  output logic [LINES-1:0] interrupt_demand, // Per-line demand
  output logic master_interrupt_enable, // Master enable of line 0
  output logic bus_request, // Priority-4 bus request, high asserts
  input wire logic grant_in, // Bus grant from processor
  output logic grant_out, // Grant passed on down the chain
  output logic sel_ack, // Selection acknowledge, high asserts
  input wire logic bbsy_i, // Bus busy as seen on the bus
  output logic bbsy_o, // Bus busy drive level
  output logic bbsy_oe, // Bus busy driven
  input wire logic ssyn_i, // Slave sync from processor
  output logic intr, // Bus interrupt line, high asserts
  output logic [6:0] vec_o, // Vector on data bits 2..8
  output logic vec_oe, // Vector driven
  output logic start_interrupt_first, // First section start, active low
  output logic start_interrupt_second, // Second section start, held high
  output logic interrupt_complete // One-cycle completion pulse
);
  import acu_irq_pkg::*;

  localparam int EVTS = LINES + 1;

  typedef struct packed {
    seq_state_t st;
    logic armed;
    logic master_en;
    logic [LINES-1:0] maint;
    logic [LINES-1:0] line_en;
    logic [LINES-1:0] done;
    logic [LINES-1:0][3:0] digit;
    logic [LINES-1:0][3:0] s1;
    logic [LINES-1:0][3:0] s2;
    logic [LINES-1:0][3:0] s3;
    logic [LINES-1:0][3:0] filt;
    logic [2:0] b1;
    logic [2:0] b2;
    logic [2:0] b3;
    logic [2:0] bf;
    logic [EVTS-1:0] evt;
    logic [EVTS-1:0] mask;
    logic irq;
    logic [31:0] rd_data;
    logic [LINES-1:0] demand;
    logic br;
    logic gout;
    logic sack;
    logic bbsy;
    logic intr;
    logic vec_oe;
    logic [6:0] vec;
    logic cmpl;
    logic start_n;
    logic hold_hi;
  } state_t;

  state_t cur_r;
  state_t cur_nxt;
  logic [LINES-1:0][3:0] resp_pins;
  logic [LINES-1:0][3:0] src;
  logic [LINES-1:0] set_done;
  logic [LINES-1:0] line_wr;
  logic [LINES-1:0] line_rd;
  logic [31:0] line_word [LINES];
  logic grant_seen;
  logic busy_seen;
  logic ssyn_seen;
  logic bus_free;
  logic start_ok;
  logic evt_wr;
  logic mask_wr;

  // Gather response pins per line and pick the done sources
  for (genvar i = 0; i < LINES; i++) begin : g_line
    assign resp_pins[i] = {power_indication[i], abandon_call_retry[i],
                           data_set_status[i], present_next_digit[i]};
    assign src[i] = cur_r.maint[i] ? cur_r.digit[i] : cur_r.filt[i];
    assign set_done[i] = |src[i];
    assign line_wr[i] = wr_en && addr == 8'(`ACU_LINE_BASE_OFS + i * `ACU_LINE_STRIDE);
    assign line_rd[i] = rd_en && addr == 8'(`ACU_LINE_BASE_OFS + i * `ACU_LINE_STRIDE);
    always_comb begin
      line_word[i] = 32'h0;
      line_word[i][`ACU_MASTER_EN_BIT] = (i == 0) ? cur_r.master_en : 1'b0;
      line_word[i][`ACU_MAINT_BIT] = cur_r.maint[i];
      line_word[i][`ACU_LINE_EN_BIT] = cur_r.line_en[i];
      line_word[i][`ACU_DONE_BIT] = cur_r.done[i];
      line_word[i][`ACU_DIGIT_LSB +: 4] = cur_r.digit[i];
      line_word[i][`ACU_RESP_LSB +: 4] = cur_r.filt[i];
    end
  end

  // Filtered bus handshake levels
  assign grant_seen = cur_r.bf[0];
  assign busy_seen = cur_r.bf[1];
  assign ssyn_seen = cur_r.bf[2];
  assign bus_free = !busy_seen && !ssyn_seen;

  // Conditions that open a transaction
  assign start_ok = (|cur_r.demand) && cur_r.master_en && cur_r.armed;

  // Global register write decode
  assign evt_wr = wr_en && addr == `ACU_EVT_STATUS_OFS;
  assign mask_wr = wr_en && addr == `ACU_EVT_MASK_OFS;

  // Next-state logic for the whole block
  always_comb begin
    logic [31:0] rd;
    logic [EVTS-1:0] evt_set;
    rd = 32'h0;
    evt_set = '0;
    cur_nxt = cur_r;
    cur_nxt.cmpl = 1'b0;

    // Three-stage pin synchronisers; a change counts once stages two and three agree
    cur_nxt.s1 = resp_pins;
    cur_nxt.s2 = cur_r.s1;
    cur_nxt.s3 = cur_r.s2;
    for (int i = 0; i < LINES; i++) begin
      for (int b = 0; b < 4; b++) begin
        if (cur_r.s2[i][b] == cur_r.s3[i][b]) begin
          cur_nxt.filt[i][b] = cur_r.s3[i][b];
        end
      end
    end
    cur_nxt.b1 = {ssyn_i, bbsy_i, grant_in};
    cur_nxt.b2 = cur_r.b1;
    cur_nxt.b3 = cur_r.b2;
    for (int b = 0; b < 3; b++) begin
      if (cur_r.b2[b] == cur_r.b3[b]) begin
        cur_nxt.bf[b] = cur_r.b3[b];
      end
    end

    // Register writes; done can be cleared by writing zero to it
    if (evt_wr) begin
      cur_nxt.evt = cur_r.evt & ~wr_data[EVTS-1:0];
    end
    if (mask_wr) begin
      cur_nxt.mask = wr_data[EVTS-1:0];
    end
    for (int i = 0; i < LINES; i++) begin
      if (line_wr[i]) begin
        if (i == 0) begin
          cur_nxt.master_en = wr_data[`ACU_MASTER_EN_BIT];
        end
        cur_nxt.maint[i] = wr_data[`ACU_MAINT_BIT];
        cur_nxt.line_en[i] = wr_data[`ACU_LINE_EN_BIT];
        cur_nxt.digit[i] = wr_data[`ACU_DIGIT_LSB +: 4];
        if (!wr_data[`ACU_DONE_BIT]) begin
          cur_nxt.done[i] = 1'b0;
        end
      end
    end

    // Falling master enable wipes pending work on every line
    if (cur_r.master_en && !cur_nxt.master_en) begin
      cur_nxt.done = '0;
    end

    // Done sources win over any clear in the same cycle
    for (int i = 0; i < LINES; i++) begin
      if (set_done[i]) begin
        cur_nxt.done[i] = 1'b1;
        evt_set[i] = !cur_r.done[i];
      end
    end
    cur_nxt.demand = cur_r.done & cur_r.line_en;

    // Re-arm only while master enable is low
    if (!cur_r.master_en) begin
      cur_nxt.armed = 1'b1;
    end

    // Interrupt transaction sequencer
    unique case (cur_r.st)
      // Idle: pass grant on, raise the request when demand is qualified
      SEQ_IDLE: begin
        cur_nxt.gout = grant_seen;
        if (start_ok) begin
          cur_nxt.br = 1'b1;
          cur_nxt.gout = 1'b0;
          cur_nxt.st = SEQ_REQ;
        end
      end
      // Request: wait for grant, give up when master enable drops
      SEQ_REQ: begin
        cur_nxt.gout = 1'b0;
        if (!cur_r.master_en) begin
          cur_nxt.br = 1'b0;
          cur_nxt.st = SEQ_IDLE;
        end else if (grant_seen) begin
          cur_nxt.br = 1'b0;
          cur_nxt.sack = 1'b1;
          cur_nxt.st = SEQ_ACK;
        end
      end
      // Acknowledged: take the bus once busy and slave sync are clear
      SEQ_ACK: begin
        cur_nxt.gout = 1'b0;
        if (bus_free) begin
          cur_nxt.bbsy = 1'b1;
          cur_nxt.sack = 1'b0;
          cur_nxt.intr = 1'b1;
          cur_nxt.vec_oe = 1'b1;
          cur_nxt.vec = {VECTOR[6:1], 1'b1};
          cur_nxt.st = SEQ_MASTER;
        end
      end
      // Master: hold interrupt and vector until slave sync answers
      SEQ_MASTER: begin
        cur_nxt.gout = 1'b0;
        if (ssyn_seen) begin
          cur_nxt.bbsy = 1'b0;
          cur_nxt.intr = 1'b0;
          cur_nxt.vec_oe = 1'b0;
          cur_nxt.vec = 7'h00;
          cur_nxt.cmpl = 1'b1;
          cur_nxt.armed = 1'b0;
          evt_set[`ACU_EVT_CMPL_BIT] = 1'b1;
          cur_nxt.st = SEQ_IDLE;
        end
      end
    endcase

    // Sticky events and the masked interrupt level
    cur_nxt.evt = cur_nxt.evt | evt_set;
    cur_nxt.irq = |(cur_nxt.evt & cur_nxt.mask);

    // Section start levels registered beside the interrupt line
    cur_nxt.start_n = !cur_nxt.intr;
    cur_nxt.hold_hi = 1'b1;

    // Read data for the cycle after the strobe
    if (rd_en) begin
      unique case (addr)
        `ACU_EVT_STATUS_OFS: rd[EVTS-1:0] = cur_r.evt;
        `ACU_EVT_MASK_OFS: rd[EVTS-1:0] = cur_r.mask;
        `ACU_SEQ_STATE_OFS: rd[3:0] = {cur_r.armed, cur_r.st};
        default: begin
          for (int i = 0; i < LINES; i++) begin
            if (line_rd[i]) begin
              rd = line_word[i];
            end
          end
        end
      endcase
    end
    cur_nxt.rd_data = rd;
  end

  // State register; reset leaves everything idle and the bus released
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_r <= '0;
      cur_r.st <= SEQ_IDLE;
      cur_r.armed <= 1'b1;
      cur_r.mask <= `ACU_EVT_MASK_RST;
      cur_r.start_n <= 1'b1;
      cur_r.hold_hi <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Register bus and software interrupt come straight from the state register
  assign rd_data = cur_r.rd_data;
  assign irq = cur_r.irq;

  // Line demand and master enable
  assign interrupt_demand = cur_r.demand;
  assign master_interrupt_enable = cur_r.master_en;

  // Bus handshake; busy is a fixed level switched by its enable
  assign bus_request = cur_r.br;
  assign grant_out = cur_r.gout;
  assign sel_ack = cur_r.sack;
  assign bbsy_o = 1'b0;
  assign bbsy_oe = cur_r.bbsy;
  assign intr = cur_r.intr;
  assign vec_o = cur_r.vec;
  assign vec_oe = cur_r.vec_oe;
  assign interrupt_complete = cur_r.cmpl;

  // Section start levels
  assign start_interrupt_first = cur_r.start_n;
  assign start_interrupt_second = cur_r.hold_hi;

endmodule : acu_interrupt_request_master

// [dv/acu_irq_checker.sv]
// Concurrent checks on the bus interrupt sequencer ports
`timescale 1ns/100ps
module acu_irq_checker #(
  parameter int LINES = 4
) (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic [LINES-1:0] interrupt_demand, // Line demand
  input wire logic master_interrupt_enable, // Master enable
  input wire logic bus_request, // Bus request
  input wire logic grant_out, // Grant passed on
  input wire logic sel_ack, // Selection acknowledge
  input wire logic ssyn_i, // Slave sync
  input wire logic bbsy_oe, // Busy driven
  input wire logic intr, // Bus interrupt
  input wire logic [6:0] vec_o, // Vector
  input wire logic vec_oe, // Vector driven
  input wire logic start_interrupt_first, // First start
  input wire logic start_interrupt_second, // Second start
  input wire logic interrupt_complete // Completion pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Steps of one transaction
  sequence s_won; $rose(intr); endsequence
  sequence s_served; interrupt_complete ##1 master_interrupt_enable [*8]; endsequence
  chk_req_cause: assert property (
    $rose(bus_request) |-> master_interrupt_enable && interrupt_demand != 0) else $error("request without cause");
  chk_grant_blocked: assert property (
    bus_request || sel_ack || intr |-> !grant_out) else $error("grant passed on");
  chk_ack_swap: assert property (
    $rose(sel_ack) |-> !bus_request && $past(bus_request)) else $error("acknowledge without request drop");
  chk_master_take: assert property (
    s_won |-> bbsy_oe && vec_oe && !sel_ack && $past(sel_ack)) else $error("mastership step wrong");
  chk_vector_bit: assert property (
    vec_oe |-> vec_o[0] && intr) else $error("vector bit 2 low");
  chk_start_map: assert property (
    start_interrupt_first == !intr && start_interrupt_second) else $error("start inputs wrong");
  chk_ssyn_answer: assert property (
    intr && ssyn_i |-> ##[1:8] !intr) else $error("no release on slave sync");
  chk_bus_release: assert property (
    $fell(intr) |-> interrupt_complete && !bbsy_oe && !vec_oe) else $error("bus not released");
  chk_pulse_once: assert property (
    interrupt_complete |=> !interrupt_complete) else $error("completion pulse too long");
  chk_no_rerequest: assert property (
    s_served |-> !bus_request) else $error("request again while enabled");
  chk_abort_request: assert property (
    $fell(master_interrupt_enable) |-> ##[0:2] !bus_request) else $error("request kept after enable drop");
endmodule : acu_irq_checker

bind acu_interrupt_request_master acu_irq_checker #(.LINES(LINES)) i_chk (
  .sys_clk(sys_clk), .resetn(resetn), .interrupt_demand(interrupt_demand),
  .master_interrupt_enable(master_interrupt_enable), .bus_request(bus_request), .grant_out(grant_out),
  .sel_ack(sel_ack), .ssyn_i(ssyn_i), .bbsy_oe(bbsy_oe), .intr(intr), .vec_o(vec_o), .vec_oe(vec_oe),
  .start_interrupt_first(start_interrupt_first), .start_interrupt_second(start_interrupt_second),
  .interrupt_complete(interrupt_complete));

// [dv/acu_bus_host_model.sv]
// Host processor and arbiter model for the bus interrupt handshake
`timescale 1ns/100ps
module acu_bus_host_model (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic [3:0] lag, // Pacing, all ones stalls grants
  input wire logic bus_request, // Request from device
  input wire logic sel_ack, // Selection acknowledge
  input wire logic bbsy_oe, // Device pulls busy
  input wire logic intr, // Bus interrupt
  input wire logic [6:0] vec_o, // Vector lines
  input wire logic vec_oe, // Vector driven
  output logic grant_in, // Grant to device
  output logic bbsy_i, // Busy line level
  output logic ssyn_i, // Slave sync
  output logic [6:0] vec_seen // Vector taken
);
  logic busy_r;
  logic [3:0] cnt_r;
  // Busy is open drain: previous master or device pulls it
  assign bbsy_i = busy_r | bbsy_oe;
  // Arbitration and vector intake paced by lag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {grant_in, ssyn_i, busy_r, cnt_r, vec_seen} <= '0;
    end else begin
      cnt_r <= (cnt_r == lag) ? 4'h0 : cnt_r + 4'h1;
      if (grant_in && !sel_ack) busy_r <= 1'b1; // Previous master still busy
      else if (cnt_r == lag) busy_r <= 1'b0;
      if (bus_request && !sel_ack && cnt_r == lag && lag != 4'hF) grant_in <= 1'b1;
      else if (sel_ack || !bus_request) grant_in <= 1'b0;
      if (intr && cnt_r == lag) begin
        ssyn_i <= 1'b1;
        vec_seen <= vec_oe ? vec_o : 7'h7F; // Released lines float to idle
      end else if (!intr) begin
        ssyn_i <= 1'b0;
      end
    end
  end
endmodule : acu_bus_host_model

// [dv/test_acu_interrupt_request_master.sv]
// Self-checking bench of the calling-unit interrupt block
`timescale 1ns/100ps
module test_acu_interrupt_request_master;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic [15:0] resp = 16'h0;
  logic [3:0] lag = 4'h0, interrupt_demand;
  logic [6:0] vec_o, vec_seen;
  logic irq, master_interrupt_enable, bus_request, grant_in, grant_out, sel_ack, bbsy_i, bbsy_o, bbsy_oe;
  logic ssyn_i, intr, vec_oe, start_interrupt_first, start_interrupt_second, interrupt_complete;
  int seed = 32'hCA06184E;
  int failures = 0, checks_done = 0, cyc = 0, l, c, k;
  always #2 sys_clk = ~sys_clk;
  acu_interrupt_request_master i_dut (.sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .present_next_digit(resp[3:0]),
    .data_set_status(resp[7:4]), .abandon_call_retry(resp[11:8]), .power_indication(resp[15:12]),
    .interrupt_demand(interrupt_demand), .master_interrupt_enable(master_interrupt_enable),
    .bus_request(bus_request), .grant_in(grant_in), .grant_out(grant_out), .sel_ack(sel_ack), .bbsy_i(bbsy_i),
    .bbsy_o(bbsy_o), .bbsy_oe(bbsy_oe), .ssyn_i(ssyn_i), .intr(intr), .vec_o(vec_o), .vec_oe(vec_oe),
    .start_interrupt_first(start_interrupt_first), .start_interrupt_second(start_interrupt_second),
    .interrupt_complete(interrupt_complete));
  acu_bus_host_model i_host (.sys_clk(sys_clk), .resetn(resetn), .lag(lag), .bus_request(bus_request),
    .sel_ack(sel_ack), .bbsy_oe(bbsy_oe), .intr(intr), .vec_o(vec_o), .vec_oe(vec_oe), .grant_in(grant_in),
    .bbsy_i(bbsy_i), .ssyn_i(ssyn_i), .vec_seen(vec_seen));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Expected line word: done flag and filtered response pins
  function automatic logic [31:0] line_exp(input logic done, input logic [3:0] pins);
    line_exp = {16'h0, pins, 4'h0, done, 7'h00};
  endfunction : line_exp
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  // Register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, e);
  endtask : rd
  // Verdict and end of run
  task automatic results;
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    chk({start_interrupt_first, bus_request, intr, bbsy_oe, vec_oe, interrupt_demand}, 9'h100);
    resetn <= 1'b1;
    rd(8'h08, 32'h8);
    rd(8'h10, 32'h0);
    rd(8'h44, 32'h0);
    // Every cause on a random line sets done, demand needs line enable
    for (c = 0; c < 4; c++) begin
      l = $unsigned($random(seed)) % 4;
      @(posedge sys_clk) resp[4*c+l] <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rd(8'(16 + 4 * l), line_exp(1'b1, 4'(1 << c)));
      chk({irq, interrupt_demand}, 5'h0);
      @(posedge sys_clk) resp[4*c+l] <= 1'b0;
      wr(8'h04, 32'h1 << l);
      wr(8'(16 + 4 * l), 32'hC0);
      repeat (6) @(posedge sys_clk);
      #1 chk({irq, interrupt_demand}, 5'h10 | 5'(1 << l));
      wr(8'(16 + 4 * l), 32'h0);
      wr(8'h00, 32'h1F);
      repeat (3) @(posedge sys_clk);
      #1 chk({irq, interrupt_demand}, 5'h0);
    end
    // Maintenance-driven transactions: fast host, slow host, stalled arbiter
    for (k = 0; k < 3; k++) begin
      l = $unsigned($random(seed)) % 4;
      lag <= 4'(k * 7 + k / 2);
      wr(8'(16 + 4 * l), 32'h1C8);
      repeat (8) @(posedge sys_clk);
      #1 chk({bus_request, interrupt_demand}, 5'(1 << l));
      wr(8'h10, (l == 0) ? 32'h1CC : 32'h4);
      if (k == 2) begin
        for (c = 0; c < 30 && bus_request !== 1'b1; c++) @(negedge sys_clk);
        wr(8'h10, (l == 0) ? 32'h1C8 : 32'h0);
        repeat (3) @(posedge sys_clk);
        #1 chk({bus_request, grant_in}, 2'b00);
      end else begin
        for (c = 0; c < 300 && interrupt_complete !== 1'b1; c++) @(negedge sys_clk);
        chk({interrupt_complete, vec_seen}, 8'hC1);
        repeat (30) @(posedge sys_clk);
        #1 chk(bus_request, 1'b0);
        rd(8'h00, 32'h10 | (32'h1 << l));
        wr(8'(16 + 4 * l), (l == 0) ? 32'hCC : 32'hC8);
        wr(8'h10, (l == 0) ? 32'hC8 : 32'h0);
        repeat (3) @(posedge sys_clk);
        #1 chk(interrupt_demand, 4'h0);
      end
      wr(8'(16 + 4 * l), 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h1F);
    end
    // Reset in mid-run while a request waits on the stalled arbiter
    wr(8'h10, 32'h1CC);
    repeat (8) @(posedge sys_clk);
    #1 chk(bus_request, 1'b1);
    @(posedge sys_clk) resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk({start_interrupt_first, bus_request, sel_ack, intr, bbsy_oe, vec_oe, interrupt_demand}, 10'h200);
    @(posedge sys_clk) resetn <= 1'b1;
    rd(8'h10, 32'h0);
    rd(8'h08, 32'h8);
    results();
  end
endmodule : test_acu_interrupt_request_master
